// ==== design/cmp_consts.svh ====
// Register map, field positions, reset values and timing counts of the comparator block.
`ifndef CMP_CONSTS_SVH
`define CMP_CONSTS_SVH

// ==========================================================
// Bus widths
`define ADDR_W        8
`define DATA_W        8

// ==========================================================
// Register addresses
`define CTRL_ADDR     8'h9b
`define MODE_ADDR     8'h9d
`define MASK_ADDR     8'h9e
`define STAT_ADDR     8'h9f

// ==========================================================
// Control register fields
`define CTRL_EN_BIT   7
`define CTRL_RES_BIT  6
`define CTRL_RISE_BIT 5
`define CTRL_FALL_BIT 4
`define CTRL_POSH_LSB 2
`define CTRL_NEGH_LSB 0
`define HYST_W        2
`define MODE_W        2

// ==========================================================
// Flag layout of status and mask registers
`define FLAG_W        2
`define FLAG_RISE     0
`define FLAG_FALL     1

// ==========================================================
// Reset values and timing
`define CTRL_RESET    8'h00
`define MODE_RESET    2'h0
`define MASK_RESET    2'h0
`define SYNC_STAGES   2

`endif

// ==== design/cmp_pkg.sv ====
// Types shared by the comparator control block.
`include "cmp_consts.svh"

package cmp_pkg;

  // ==========================================================
  // Hysteresis settings driven to the analog core
  typedef enum logic [`HYST_W-1:0] {
    HYST_OFF  = 2'b00,
    HYST_5MV  = 2'b01,
    HYST_10MV = 2'b10,
    HYST_20MV = 2'b11
  } hyst_type;

  // ==========================================================
  // One cycle of the register port
  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [`ADDR_W-1:0] addr;
    logic [`DATA_W-1:0] wdata;
  } bus_req_type;

  // ==========================================================
  // Settings forwarded to the analog comparator
  typedef struct packed {
    logic              power_on;
    hyst_type          pos_hyst_sel;
    hyst_type          neg_hyst_sel;
    logic [`MODE_W-1:0] resp_mode;
  } analog_cfg_type;

endpackage

// ==== design/edge_sync.sv ====
// Two-stage synchroniser that brings the raw comparator result into the clock domain.
`include "cmp_consts.svh"

module edge_sync (
  // Clock and reset.
  input  logic clk,
  input  logic rst_n,
  // Asynchronous level in, synchronous level out.
  input  logic async_in,
  output logic sync_out
);

  logic [`SYNC_STAGES-1:0] stage_r;
  logic [`SYNC_STAGES-1:0] stage_nxt;

  // ==========================================================
  // Shift chain; each stage only feeds the next one.
  assign stage_nxt[0] = async_in;
  for (genvar i = 1; i < `SYNC_STAGES; i++) begin : g_stage
    assign stage_nxt[i] = stage_r[i-1];
  end

  // Stages clear on reset and shift on every edge.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stage_r <= '0;
    end else begin
      stage_r <= stage_nxt;
    end
  end

  assign sync_out = stage_r[`SYNC_STAGES-1];

endmodule

// ==== design/comparator_edge_control.sv ====
// Comparator control: enable, hysteresis, response mode, edge flags, interrupt, outputs.
//
// Design decisions made here: the address-and-strobe port and the placing of the registers.
`include "cmp_consts.svh"

module comparator_edge_control (
  // Clock and reset.
  input  logic                    clk,
  input  logic                    rst_n,
  // Register port.
  input  cmp_pkg::bus_req_type    bus_req,
  output logic [`DATA_W-1:0]      rd_data,
  // Analog comparator core.
  input  logic                    comp_analog,
  output cmp_pkg::analog_cfg_type analog_cfg,
  // Pin crossbar and reset logic.
  output logic                    latched_compare_out,
  output logic                    raw_compare_out,
  output logic                    reset_src_out,
  // Interrupt request.
  output logic                    irq
);
  import cmp_pkg::*;

  // ==========================================================
  // Declarations
  analog_cfg_type      cfg_r;
  analog_cfg_type      cfg_nxt;
  logic [`FLAG_W-1:0]  flags_r;
  logic [`FLAG_W-1:0]  flags_nxt;
  logic [`FLAG_W-1:0]  mask_r;
  logic [`FLAG_W-1:0]  mask_nxt;
  logic [`FLAG_W-1:0]  edge_hit;
  logic [`DATA_W-1:0]  rd_r;
  logic [`DATA_W-1:0]  rd_nxt;
  logic                latched_r;
  logic                latched_nxt;
  logic                rst_src_r;
  logic                prev_r;
  logic                irq_r;
  logic                irq_nxt;
  logic                sync_q;
  logic                wr_ctrl;
  logic                wr_mode;
  logic                wr_mask;
  logic                wr_stat;
  logic                rd_ctrl;

  // Address match used by the write strobes and rd_ctrl; the read data mux decodes by case.
  function automatic logic reg_hit(input logic [`ADDR_W-1:0] addr,
                                   input logic [`ADDR_W-1:0] base);
    return addr == base;
  endfunction

  // ==========================================================
  // Register port decode
  assign wr_ctrl = bus_req.wr && reg_hit(bus_req.addr, `CTRL_ADDR);
  assign wr_mode = bus_req.wr && reg_hit(bus_req.addr, `MODE_ADDR);
  assign wr_mask = bus_req.wr && reg_hit(bus_req.addr, `MASK_ADDR);
  assign wr_stat = bus_req.wr && reg_hit(bus_req.addr, `STAT_ADDR);
  assign rd_ctrl = bus_req.rd && reg_hit(bus_req.addr, `CTRL_ADDR);

  // ==========================================================
  // Synchronised result and edge detection
  // two-stage synchroniser
  edge_sync u_sync (
    .clk      (clk),
    .rst_n    (rst_n),
    .async_in (comp_analog),
    .sync_out (sync_q)
  );

  // Edges count only while the comparator is powered, so a disabled core cannot flag.
  always_comb begin
    edge_hit             = '0;
    edge_hit[`FLAG_RISE] = cfg_r.power_on && sync_q && !prev_r;
    edge_hit[`FLAG_FALL] = cfg_r.power_on && !sync_q && prev_r;
  end

  // ==========================================================
  // Configuration registers
  always_comb begin
    cfg_nxt  = cfg_r;
    mask_nxt = mask_r;
    if (wr_ctrl) begin
      cfg_nxt.power_on     = bus_req.wdata[`CTRL_EN_BIT];
      cfg_nxt.pos_hyst_sel = hyst_type'(bus_req.wdata[`CTRL_POSH_LSB +: `HYST_W]);
      cfg_nxt.neg_hyst_sel = hyst_type'(bus_req.wdata[`CTRL_NEGH_LSB +: `HYST_W]);
    end
    if (wr_mode) begin
      cfg_nxt.resp_mode = bus_req.wdata[`MODE_W-1:0];
    end
    if (wr_mask) begin
      mask_nxt = bus_req.wdata[`FLAG_W-1:0];
    end
  end

  // hysteresis and mode held for the core
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_r  <= analog_cfg_type'({1'b0, HYST_OFF, HYST_OFF, `MODE_RESET});
      mask_r <= `MASK_RESET;
    end else begin
      cfg_r  <= cfg_nxt;
      mask_r <= mask_nxt;
    end
  end

  // ==========================================================
  // Sticky edge flags
  // Control writes load the flag bits, status writes clear where a one is written.
  // An edge in the same cycle as a clear still sets the flag.
  always_comb begin
    flags_nxt = flags_r;
    for (int i = 0; i < `FLAG_W; i++) begin
      if (wr_ctrl) begin
        flags_nxt[i] = bus_req.wdata[`CTRL_RISE_BIT - i];
      end else if (wr_stat && bus_req.wdata[i]) begin
        flags_nxt[i] = 1'b0;
      end
      if (edge_hit[i]) begin
        flags_nxt[i] = 1'b1;
      end
    end
  end

  assign irq_nxt = |(flags_nxt & mask_nxt);

  // Flags and interrupt level register together so they never disagree.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flags_r <= '0;
      irq_r   <= 1'b0;
    end else begin
      flags_r <= flags_nxt;
      irq_r   <= irq_nxt;
    end
  end

  // ==========================================================
  // Latched output and reset source
  // latched copy forced low when off
  assign latched_nxt = sync_q && cfg_r.power_on;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      latched_r <= 1'b0;
      rst_src_r <= 1'b0;
      prev_r    <= 1'b0;
    end else begin
      latched_r <= latched_nxt;
      rst_src_r <= latched_nxt;
      prev_r    <= sync_q;
    end
  end

  // ==========================================================
  // Read data, valid in the cycle after the read strobe only
  always_comb begin
    rd_nxt = '0;
    if (bus_req.rd) begin
      case (bus_req.addr)
        `CTRL_ADDR: begin
          rd_nxt[`CTRL_EN_BIT]                  = cfg_r.power_on;
          rd_nxt[`CTRL_RES_BIT]                 = latched_r;
          rd_nxt[`CTRL_RISE_BIT]                = flags_r[`FLAG_RISE];
          rd_nxt[`CTRL_FALL_BIT]                = flags_r[`FLAG_FALL];
          rd_nxt[`CTRL_POSH_LSB +: `HYST_W]     = cfg_r.pos_hyst_sel;
          rd_nxt[`CTRL_NEGH_LSB +: `HYST_W]     = cfg_r.neg_hyst_sel;
        end
        `MODE_ADDR: begin
          rd_nxt[`MODE_W-1:0] = cfg_r.resp_mode;
        end
        `MASK_ADDR: begin
          rd_nxt[`FLAG_W-1:0] = mask_r;
        end
        `STAT_ADDR: begin
          rd_nxt[`FLAG_W-1:0] = flags_r;
        end
        default: begin
          rd_nxt = '0;
        end
      endcase
    end
  end

  // Read data register.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_r <= '0;
    end else begin
      rd_r <= rd_nxt;
    end
  end

  // ==========================================================
  // Outputs
  assign rd_data             = rd_r;
  assign analog_cfg          = cfg_r;
  assign latched_compare_out = latched_r;
  assign reset_src_out       = rst_src_r;
  assign irq                 = irq_r;
  // unclocked raw path gated by enable
  assign raw_compare_out     = comp_analog && cfg_r.power_on;

  // ==========================================================
  // Assertions
  raw_gate_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    !cfg_r.power_on |-> !raw_compare_out && !analog_cfg.power_on)
    else $error("Raw output or core power active while disabled.");

  raw_follow_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    cfg_r.power_on |-> raw_compare_out == comp_analog)
    else $error("Raw output does not follow the analog result.");

  latched_off_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    !cfg_r.power_on |=> !latched_compare_out)
    else $error("Latched output high after a disabled cycle.");

  sync_delay_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    cfg_r.power_on ##1 cfg_r.power_on ##1 cfg_r.power_on
      |=> latched_compare_out == $past(comp_analog, 3))
    else $error("Latched output not three cycles behind the analog result.");

  rise_set_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    $rose(sync_q) && cfg_r.power_on |=> flags_r[`FLAG_RISE])
    else $error("Rising edge did not set the rising flag.");

  fall_set_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    $fell(sync_q) && cfg_r.power_on |=> flags_r[`FLAG_FALL])
    else $error("Falling edge did not set the falling flag.");

  flag_sticky_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    flags_r[`FLAG_RISE] && !wr_ctrl && !wr_stat |=> flags_r[`FLAG_RISE])
    else $error("Rising flag cleared without a software write.");

  irq_cause_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    irq |-> (flags_r[`FLAG_RISE] && mask_r[`FLAG_RISE])
         || (flags_r[`FLAG_FALL] && mask_r[`FLAG_FALL]))
    else $error("Interrupt raised without an unmasked flag.");

  result_read_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    rd_ctrl |=> rd_data[`CTRL_RES_BIT] == $past(latched_compare_out)
             && $stable(flags_r) || $past(edge_hit) != '0)
    else $error("Result bit read wrong or disturbed the flags.");

  enable_write_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    wr_ctrl |=> analog_cfg.power_on == $past(bus_req.wdata[`CTRL_EN_BIT]))
    else $error("Enable bit not taken from the control write.");

  hyst_write_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    wr_ctrl |=> {analog_cfg.pos_hyst_sel, analog_cfg.neg_hyst_sel}
             == $past(bus_req.wdata[3:0]))
    else $error("Hysteresis fields not taken from bits three to zero.");

  mode_write_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    wr_mode |=> analog_cfg.resp_mode == $past(bus_req.wdata[`MODE_W-1:0]))
    else $error("Response mode not forwarded after a mode write.");

  fall_sticky_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    flags_r[`FLAG_FALL] && !wr_ctrl && !wr_stat |=> flags_r[`FLAG_FALL])
    else $error("Falling flag cleared without a software write.");

  irq_level_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    (flags_r[`FLAG_RISE] && mask_r[`FLAG_RISE])
      || (flags_r[`FLAG_FALL] && mask_r[`FLAG_FALL]) |-> irq)
    else $error("Unmasked flag set but no interrupt raised.");

  reset_src_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    reset_src_out == latched_compare_out)
    else $error("Reset source copy differs from the latched output.");

endmodule

// ==== sim/analog_core_model.sv ====
// Behavioural analog comparator core that answers the block's settings.
`include "cmp_consts.svh"

module analog_core_model (
  // Clock for the unpowered noise pattern.
  input  logic                    clk,
  // Settings from the block and the level that the bench applies.
  input  cmp_pkg::analog_cfg_type cfg,
  input  logic                    level,
  // Comparison result towards the block.
  output logic                    comp_out
);
  timeunit 1ns;
  timeprecision 1ps;
  import cmp_pkg::*;

  logic level_d;
  logic noise_r;

  initial begin
    level_d = 1'b0;
    noise_r = 1'b0;
  end

  // response mode: a slower setting answers later, always within a cycle.
  always @(level) begin
    level_d <= #(1 + 2 * cfg.resp_mode) level;
  end

  // unpowered core: a changing pattern, since the result is then meaningless.
  always @(posedge clk) begin
    noise_r <= ~noise_r;
  end

  // powered core follows the applied level with no clock involved.
  assign comp_out = cfg.power_on ? level_d : noise_r;
endmodule

// ==== sim/comparator_edge_control_test.sv ====
// Self-checking bench for the comparator control block.
`include "cmp_consts.svh"
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin n_mismatch++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); end end

module comparator_edge_control_test;
  timeunit 1ns;
  timeprecision 1ps;
  import cmp_pkg::*;

  logic               clk;
  logic               clk_run;
  logic               rst_n;
  bus_req_type        bus_req;
  logic [`DATA_W-1:0] rd_data;
  logic               comp_analog;
  analog_cfg_type     analog_cfg;
  logic               latched_compare_out;
  logic               raw_compare_out;
  logic               reset_src_out;
  logic               irq;
  logic               level;
  logic               prev;
  logic [7:0]         v;
  logic [31:0]        r;
  int                 seed;
  int                 n_mismatch;
  int                 cmp_count;
  logic [7:0]         regs [4] = '{`CTRL_ADDR, `MODE_ADDR, `MASK_ADDR, `STAT_ADDR};

  comparator_edge_control dut (
    .clk                 (clk),
    .rst_n               (rst_n),
    .bus_req             (bus_req),
    .rd_data             (rd_data),
    .comp_analog         (comp_analog),
    .analog_cfg          (analog_cfg),
    .latched_compare_out (latched_compare_out),
    .raw_compare_out     (raw_compare_out),
    .reset_src_out       (reset_src_out),
    .irq                 (irq)
  );

  analog_core_model core (
    .clk      (clk),
    .cfg      (analog_cfg),
    .level    (level),
    .comp_out (comp_analog)
  );

  // Clock that can be halted to show the unclocked path.
  initial begin
    clk = 1'b0;
    forever #4 clk = clk_run ? ~clk : clk;
  end

  // Expected control register word.
  function automatic logic [7:0] ctrl_word(logic en, logic res, logic ri, logic fa,
                                           logic [3:0] h);
    return {en, res, ri, fa, h};
  endfunction

  // Expected interrupt level from flags and mask.
  function automatic logic exp_irq(logic ri, logic fa, logic [1:0] m);
    return (ri & m[`FLAG_RISE]) | (fa & m[`FLAG_FALL]);
  endfunction

  // One write cycle; ends at the edge where the write lands.
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    bus_req <= '0;
  endtask

  // One read cycle; data are taken in the cycle after the strobe.
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk);
    bus_req <= '0;
    #1 d = rd_data;
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic end_sim();
    if (n_mismatch == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // Cuts a hang short.
  initial begin
    #100000;
    n_mismatch++;
    end_sim();
  end

  // Main sequence.
  initial begin
    seed = 61;
    n_mismatch = 0;
    cmp_count = 0;
    clk_run = 1'b1;
    rst_n = 1'b0;
    bus_req = '0;
    level = 1'b0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    `CHK(analog_cfg, 7'h00)
    `CHK(raw_compare_out, 1'b0)
    for (int i = 0; i < 4; i++) begin
      rd_reg(regs[i], v);
      `CHK(v, 8'h00)
    end
    // Unmapped place: write ignored, read gives zero.
    wr_reg(8'h9c, 8'hff);
    rd_reg(8'h9c, v);
    `CHK(v, 8'h00)
    // Every hysteresis code on both fields, then every response mode.
    for (int i = 0; i < 16; i++) begin
      wr_reg(`CTRL_ADDR, 8'h80 | i[7:0]);
      #1;
      `CHK(analog_cfg.power_on, 1'b1)
      `CHK(analog_cfg.pos_hyst_sel, i[3:2])
      `CHK(analog_cfg.neg_hyst_sel, i[1:0])
      rd_reg(`CTRL_ADDR, v);
      `CHK(v[3:0], i[3:0])
    end
    for (int m = 0; m < 4; m++) begin
      wr_reg(`MODE_ADDR, m[7:0]);
      #1;
      `CHK(analog_cfg.resp_mode, m[1:0])
      rd_reg(`MODE_ADDR, v);
      `CHK(v, {6'h00, m[1:0]})
    end
    // Rising then falling edge with flags, mask and interrupt.
    wr_reg(`CTRL_ADDR, 8'h80);
    wait_cyc(6);
    wr_reg(`STAT_ADDR, 8'h03);
    wr_reg(`MASK_ADDR, 8'h01);
    level <= 1'b1;
    wait_cyc(8);
    rd_reg(`CTRL_ADDR, v);
    `CHK(v, 8'he0)
    `CHK(latched_compare_out, 1'b1)
    `CHK(reset_src_out, 1'b1)
    `CHK(irq, 1'b1)
    @(posedge clk) level <= 1'b0;
    wait_cyc(8);
    rd_reg(`CTRL_ADDR, v);
    `CHK(v, 8'hb0)
    rd_reg(`STAT_ADDR, v);
    `CHK(v, 8'h03)
    wr_reg(`STAT_ADDR, 8'h01);
    wait_cyc(1);
    `CHK(irq, 1'b0)
    wr_reg(`MASK_ADDR, 8'h02);
    wait_cyc(1);
    `CHK(irq, 1'b1)
    // Software may set both flags through the control word, then clear one by status.
    wr_reg(`CTRL_ADDR, 8'hb0);
    rd_reg(`CTRL_ADDR, v);
    `CHK(v, 8'hb0)
    wr_reg(`STAT_ADDR, 8'h02);
    rd_reg(`STAT_ADDR, v);
    `CHK(v, 8'h01)
    `CHK(irq, 1'b0)
    // Halted clock: the unclocked output still follows.
    @(posedge clk) clk_run = 1'b0;
    #20 level = 1'b1;
    #20;
    `CHK(raw_compare_out, 1'b1)
    level = 1'b0;
    // Restart off the half-period grid so the clock resumes one way only.
    #21;
    `CHK(raw_compare_out, 1'b0)
    clk_run = 1'b1;
    // Disabled: outputs low, core off, edges ignored.
    @(posedge clk) level <= 1'b1;
    wait_cyc(6);
    wr_reg(`CTRL_ADDR, 8'h00);
    #1;
    `CHK(raw_compare_out, 1'b0)
    `CHK(analog_cfg.power_on, 1'b0)
    wait_cyc(4);
    `CHK(latched_compare_out, 1'b0)
    `CHK(reset_src_out, 1'b0)
    @(posedge clk) level <= 1'b0;
    wait_cyc(6);
    rd_reg(`CTRL_ADDR, v);
    `CHK(v[5:4], 2'b00)
    // Random settings, masks and levels; spurious edges after enabling are cleared.
    wr_reg(`CTRL_ADDR, 8'h80);
    wait_cyc(6);
    prev = level;
    repeat (40) begin
      r = $random(seed);
      wr_reg(`MASK_ADDR, {6'h00, r[8:7]});
      wr_reg(`MODE_ADDR, {6'h00, r[5:4]});
      wr_reg(`CTRL_ADDR, {4'h8, r[3:0]});
      level <= r[6];
      wait_cyc(8);
      rd_reg(`CTRL_ADDR, v);
      `CHK(v, ctrl_word(1'b1, r[6], r[6] & ~prev, ~r[6] & prev, r[3:0]))
      `CHK(irq, exp_irq(r[6] & ~prev, ~r[6] & prev, r[8:7]))
      `CHK(raw_compare_out, r[6])
      rd_reg(`MASK_ADDR, v);
      `CHK(v, {6'h00, r[8:7]})
      prev = r[6];
    end
    // Reset in mid-run: registers and outputs return to zero at once.
    @(posedge clk) rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    `CHK(analog_cfg, 7'h00)
    `CHK({latched_compare_out, reset_src_out, irq, raw_compare_out}, 4'h0)
    rd_reg(`CTRL_ADDR, v);
    `CHK(v, 8'h00)
    rd_reg(`STAT_ADDR, v);
    `CHK(v, 8'h00)
    end_sim();
  end
endmodule
